/* logic/rbs_pkg.sv */
package rbs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam int NUM_CHECKS = 5;

    // register offsets
    localparam logic [7:0] OFS_FILTER_SETUP = 8'h00;
    localparam logic [7:0] OFS_USER_INFO_A  = 8'h2C;
    localparam logic [7:0] OFS_USER_INFO_B  = 8'h2D;
    localparam logic [7:0] OFS_CHECK_RESULT = 8'h2F;

    // field positions and reset values
    localparam int ALIGN_ENABLE_BIT = 0;
    localparam logic [23:0] FILTER_SETUP_RST = 24'h000000;
    localparam logic [23:0] USER_INFO_RST    = 24'h000000;
    localparam logic [23:0] CHECK_RESULT_RST = 24'h000000;
    localparam logic [3:0]  CHECK_PASS       = 4'hA;
    localparam logic [3:0]  CHECK_FAIL       = 4'hF;

    // timing
    localparam int CLK_KHZ         = 100_000;
    localparam int BUILT_IN_CHECK_RESULT_TIME_MS = 60;
    localparam int BUILT_IN_CHECK_RESULT_CYCLES = BUILT_IN_CHECK_RESULT_TIME_MS * CLK_KHZ;
    localparam int BOOT_LATCH_CYCLE = 4;
    localparam int MOD_DIV_CYCLES  = 50;
    localparam int WORD_PERIOD_CYCLES = 25_000;

    typedef enum logic [2:0] {
        ST_HOLD     = 3'b000,
        ST_TEST     = 3'b001,
        ST_EEPROM   = 3'b010,
        ST_WAIT_MCU = 3'b011,
        ST_RUN      = 3'b100
    } boot_state_e;

endpackage

/* logic/input_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; a change counts once stages two and three agree
module input_sync3
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic async_i,
    output logic      level_o
);

    logic meta;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta    <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            meta   <= async_i;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3)
            begin
                level_o <= stage3;
            end
        end
    end

endmodule // input_sync3

`default_nettype wire

/* logic/reset_boot_sync_control.sv */
// Overview of operation
// - reset is active low; sequence starts when reset input returns high
// - after release, run self-tests of memories and execution unit before boot
// - self-test lasts 60 ms; configuration commands refused until it ends
// - each test writes one result nibble, A pass, F fail; all pass 0x0AAAAA
// - boot level latched after release; high is EEPROM, low is microcontroller
// - EEPROM mode fetches configuration itself, then starts filtering
// - microcontroller mode idles until configured and started by the controller
// - each sync rising edge yields align pulse retimed to modulator clock
// - align pulse generation gated by enable bit in filter setup register
// - align pulse restarts filter timing; next word one sample period later
// - sync at exactly the word rate leaves output cadence undisturbed
// - two user info registers hold any 24-bit value, no hardware effect
`timescale 1ns/1ps
`default_nettype none

module reset_boot_sync_control
    import rbs_pkg::*;
#(
    parameter int BUILT_IN_CHECK_RESULT_LEN = rbs_pkg::BUILT_IN_CHECK_RESULT_CYCLES,
    parameter int MOD_DIV      = rbs_pkg::MOD_DIV_CYCLES,
    parameter int WORD_PERIOD  = rbs_pkg::WORD_PERIOD_CYCLES
)
(
    input  wire logic                            clk_i,
    input  wire logic                            nrst_i,
    input  wire logic                            boot_mode_i,
    input  wire logic                            sync_i,
    input  wire logic [rbs_pkg::NUM_CHECKS-1:0]  check_fail_i,
    input  wire logic                            eeprom_done_i,
    input  wire logic                            filter_start_i,
    input  wire logic                            cfg_we_i,
    input  wire logic                            cfg_re_i,
    input  wire logic [rbs_pkg::ADDR_W-1:0]      cfg_addr_i,
    input  wire logic [rbs_pkg::DATA_W-1:0]      cfg_wdata_i,
    output logic                                 cfg_ready_o,
    output logic [rbs_pkg::DATA_W-1:0]           rdata_o,
    output logic                                 rd_valid_o,
    output logic                                 boot_eeprom_o,
    output logic                                 eeprom_fetch_o,
    output logic                                 filter_run_o,
    output logic                                 filter_restart_o,
    output logic                                 word_strobe_o,
    output logic                                 modulator_clk_o,
    output logic                                 modulator_align_pulse_o
);

    import rbs_pkg::*;

    localparam int PHASE_LEN = BUILT_IN_CHECK_RESULT_LEN / NUM_CHECKS;

    boot_state_e state;
    logic        rel_meta;
    logic        rel_sync;
    logic        boot_lvl;
    logic        sync_lvl;
    logic        sync_prev;
    logic        sync_rise;
    logic [31:0] test_cnt;
    logic [2:0]  phase;
    logic [23:0] filter_setup_word;
    logic [23:0] user_info_word_a;
    logic [23:0] user_info_word_b;
    logic [23:0] built_in_check_result;
    logic [31:0] mod_cnt;
    logic        mod_tick;
    logic        align_pending;
    logic        align_issue;
    logic [31:0] word_cnt;
    logic        cfg_write;
    logic        cfg_read;
    logic        align_enable;

    function automatic logic [23:0] read_reg(input logic [7:0] addr, input logic [23:0] setup,
                                             input logic [23:0] ua, input logic [23:0] ub,
                                             input logic [23:0] res);
        unique case (addr)
            OFS_FILTER_SETUP: return setup;
            OFS_USER_INFO_A:  return ua;
            OFS_USER_INFO_B:  return ub;
            OFS_CHECK_RESULT: return res;
            default:          return 24'h000000;
        endcase
    endfunction

    // reset release brought onto the clock
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rel_meta <= 1'b0;
            rel_sync <= 1'b0;
        end
        else
        begin
            rel_meta <= 1'b1;
            rel_sync <= rel_meta;
        end
    end

    input_sync3 u_boot_sync
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (boot_mode_i),
        .level_o (boot_lvl)
    );

    input_sync3 u_sync_sync
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (sync_i),
        .level_o (sync_lvl)
    );

    assign sync_rise    = sync_lvl && !sync_prev;
    assign mod_tick     = (mod_cnt == 32'(MOD_DIV - 1));
    assign align_issue  = mod_tick && align_pending;
    assign align_enable = filter_setup_word[ALIGN_ENABLE_BIT];
    assign cfg_write    = cfg_we_i && cfg_ready_o;
    assign cfg_read     = cfg_re_i && cfg_ready_o;

    // boot sequencer
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state    <= ST_HOLD;
            test_cnt <= 32'h0;
            phase    <= 3'h0;
        end
        else
        begin
            unique case (state)
                ST_HOLD:
                begin
                    if (rel_sync)
                    begin
                        state <= ST_TEST;
                    end
                end
                ST_TEST:
                begin
                    if (test_cnt == 32'(PHASE_LEN - 1))
                    begin
                        test_cnt <= 32'h0;
                        if (phase == 3'(NUM_CHECKS - 1))
                        begin
                            state <= boot_eeprom_o ? ST_EEPROM : ST_WAIT_MCU;
                        end
                        else
                        begin
                            phase <= phase + 3'h1;
                        end
                    end
                    else
                    begin
                        test_cnt <= test_cnt + 32'h1;
                    end
                end
                ST_EEPROM:
                begin
                    if (eeprom_done_i)
                    begin
                        state <= ST_RUN;
                    end
                end
                ST_WAIT_MCU:
                begin
                    if (filter_start_i)
                    begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    state <= ST_RUN;
                end
                default:
                begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // boot level latched shortly after release, once the synchroniser has settled
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            boot_eeprom_o <= 1'b0;
        end
        else if (state == ST_TEST && phase == 3'h0 && test_cnt == 32'(BOOT_LATCH_CYCLE))
        begin
            boot_eeprom_o <= boot_lvl;
        end
    end

    // self-test results, one nibble per test
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            built_in_check_result <= CHECK_RESULT_RST;
        end
        else if (state == ST_TEST && test_cnt == 32'(PHASE_LEN - 1))
        begin
            built_in_check_result[4*phase +: 4] <= check_fail_i[phase] ? CHECK_FAIL
                                                                       : CHECK_PASS;
        end
    end

    // status outputs
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cfg_ready_o    <= 1'b0;
            eeprom_fetch_o <= 1'b0;
            filter_run_o   <= 1'b0;
        end
        else
        begin
            cfg_ready_o    <= (state == ST_EEPROM) || (state == ST_WAIT_MCU)
                           || (state == ST_RUN);
            eeprom_fetch_o <= (state == ST_EEPROM);
            filter_run_o   <= (state == ST_RUN);
        end
    end

    // configuration registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            filter_setup_word <= FILTER_SETUP_RST;
            user_info_word_a  <= USER_INFO_RST;
            user_info_word_b  <= USER_INFO_RST;
        end
        else if (cfg_write)
        begin
            if (cfg_addr_i == OFS_FILTER_SETUP)
            begin
                filter_setup_word <= cfg_wdata_i;
            end
            if (cfg_addr_i == OFS_USER_INFO_A)
            begin
                user_info_word_a <= cfg_wdata_i;
            end
            if (cfg_addr_i == OFS_USER_INFO_B)
            begin
                user_info_word_b <= cfg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o    <= 24'h000000;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= cfg_read;
            if (cfg_read)
            begin
                rdata_o <= read_reg(cfg_addr_i, filter_setup_word, user_info_word_a,
                                    user_info_word_b, built_in_check_result);
            end
        end
    end

    // modulator clock divider
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mod_cnt         <= 32'h0;
            modulator_clk_o <= 1'b0;
        end
        else
        begin
            mod_cnt         <= mod_tick ? 32'h0 : mod_cnt + 32'h1;
            modulator_clk_o <= (mod_cnt < 32'(MOD_DIV / 2));
        end
    end

    // sync edge held until the next modulator clock tick
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync_prev     <= 1'b0;
            align_pending <= 1'b0;
        end
        else
        begin
            sync_prev     <= sync_lvl;
            align_pending <= (align_pending && !mod_tick) || (sync_rise && align_enable);
        end
    end

    // align pulse out: pin high for one modulator period, restart one cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            modulator_align_pulse_o <= 1'b0;
            filter_restart_o        <= 1'b0;
        end
        else
        begin
            filter_restart_o <= align_issue;
            if (mod_tick)
            begin
                modulator_align_pulse_o <= align_pending;
            end
        end
    end

    // output word cadence; a restart on the wrap cycle changes nothing
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            word_cnt      <= 32'h0;
            word_strobe_o <= 1'b0;
        end
        else if (state != ST_RUN)
        begin
            word_cnt      <= 32'h0;
            word_strobe_o <= 1'b0;
        end
        else
        begin
            word_strobe_o <= (word_cnt == 32'(WORD_PERIOD - 1));
            if (word_cnt == 32'(WORD_PERIOD - 1) || align_issue)
            begin
                word_cnt <= 32'h0;
            end
            else
            begin
                word_cnt <= word_cnt + 32'h1;
            end
        end
    end

    // cycles since reset release, for checking only
    logic [31:0] age;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            age <= 32'h0;
        end
        else if (rel_sync && age != 32'hFFFFFFFF)
        begin
            age <= age + 32'h1;
        end
    end

    property p_release_starts;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_HOLD && rel_sync) |=> state == ST_TEST;
    endproperty
    a_release_starts: assert property (p_release_starts)
        else $error("sequence did not start on reset release");

    property p_tests_before_boot;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_EEPROM || state == ST_WAIT_MCU) |-> built_in_check_result[19:16] != 4'h0;
    endproperty
    a_tests_before_boot: assert property (p_tests_before_boot)
        else $error("boot entered before all tests finished");

    property p_no_early_cmd;
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_ready_o |-> age >= 32'(BUILT_IN_CHECK_RESULT_LEN - NUM_CHECKS);
    endproperty
    a_no_early_cmd: assert property (p_no_early_cmd)
        else $error("commands accepted before self-test time elapsed");

    property p_first_nibble;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_TEST && phase == 3'h0 && test_cnt == 32'(PHASE_LEN - 1))
        |=> built_in_check_result[3:0] == ($past(check_fail_i[0]) ? CHECK_FAIL : CHECK_PASS);
    endproperty
    a_first_nibble: assert property (p_first_nibble)
        else $error("first test nibble wrong");

    property p_boot_path;
        @(posedge clk_i) disable iff (!nrst_i)
        ($past(state) == ST_TEST && state != ST_TEST) |-> (state == ST_EEPROM) == boot_eeprom_o;
    endproperty
    a_boot_path: assert property (p_boot_path)
        else $error("boot path does not match latched mode");

    property p_eeprom_done;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_EEPROM && eeprom_done_i) |=> state == ST_RUN ##1 filter_run_o;
    endproperty
    a_eeprom_done: assert property (p_eeprom_done)
        else $error("eeprom completion did not start filter");

    property p_mcu_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_WAIT_MCU && !filter_start_i) |=> state == ST_WAIT_MCU;
    endproperty
    a_mcu_idle: assert property (p_mcu_idle)
        else $error("left idle without start command");

    property p_align_out;
        @(posedge clk_i) disable iff (!nrst_i)
        align_issue |=> filter_restart_o && modulator_align_pulse_o ##1 !filter_restart_o;
    endproperty
    a_align_out: assert property (p_align_out)
        else $error("align pulse not produced");

    property p_gate;
        @(posedge clk_i) disable iff (!nrst_i)
        (!align_enable && !align_pending) |=> !align_pending;
    endproperty
    a_gate: assert property (p_gate)
        else $error("sync pending while generation disabled");

    property p_restart;
        @(posedge clk_i) disable iff (!nrst_i)
        (align_issue && state == ST_RUN && word_cnt != 32'(WORD_PERIOD - 1))
        |=> word_cnt == 32'h0 ##1 !word_strobe_o;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not reset word timing");

    property p_cadence;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_RUN && word_cnt == 32'(WORD_PERIOD - 1)) |=> word_strobe_o;
    endproperty
    a_cadence: assert property (p_cadence)
        else $error("word strobe lost at cadence boundary");

    property p_user_a;
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg_write && cfg_addr_i == OFS_USER_INFO_A) |=> user_info_word_a == $past(cfg_wdata_i);
    endproperty
    a_user_a: assert property (p_user_a)
        else $error("user info word not stored");

    c_eeprom_boot: cover property (@(posedge clk_i) disable iff (!nrst_i)
        state == ST_EEPROM ##1 state == ST_RUN);
    c_mcu_boot: cover property (@(posedge clk_i) disable iff (!nrst_i)
        state == ST_WAIT_MCU ##1 state == ST_RUN);
    c_align: cover property (@(posedge clk_i) disable iff (!nrst_i)
        align_issue && state == ST_RUN);

endmodule // reset_boot_sync_control

`default_nettype wire

/* bench/cfg_source_model.sv */
`timescale 1ns/1ps
`default_nettype none

// stands in for the configuration source: EEPROM loader or microcontroller
module cfg_source_model
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ready_i,
    input  wire logic       eeprom_mode_i,
    input  wire logic [7:0] delay_i,
    output logic            done_o,
    output logic            start_o
);
    logic [8:0] cnt;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt     <= 9'h000;
            done_o  <= 1'b0;
            start_o <= 1'b0;
        end
        else
        begin
            // nothing is issued before the self test has ended
            if (ready_i && cnt <= {1'b0, delay_i})
            begin
                cnt <= cnt + 9'h001;
            end
            done_o  <= ready_i && eeprom_mode_i && cnt == {1'b0, delay_i};
            start_o <= ready_i && !eeprom_mode_i && cnt == {1'b0, delay_i};
        end
    end
endmodule // cfg_source_model

`default_nettype wire

/* bench/reset_boot_sync_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_boot_sync_control_tb;
    import rbs_pkg::*;
    localparam int ST = 100;
    localparam int MD = 4;
    localparam int WP = 40;
    logic        clk_i, nrst_i, boot_mode_i, sync_i, cfg_we_i, cfg_re_i;
    logic [4:0]  check_fail_i;
    logic [7:0]  cfg_addr_i, delay;
    logic [23:0] cfg_wdata_i, rdata_o;
    logic        eeprom_done_i, filter_start_i, cfg_ready_o, rd_valid_o, boot_eeprom_o;
    logic        eeprom_fetch_o, filter_run_o, filter_restart_o, word_strobe_o;
    logic        modulator_clk_o, modulator_align_pulse_o;
    int          error_cnt, cmp_count, cycles;
    logic [31:0] seed = 32'h00000044;

    reset_boot_sync_control #(.BUILT_IN_CHECK_RESULT_LEN(ST), .MOD_DIV(MD), .WORD_PERIOD(WP)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .boot_mode_i(boot_mode_i), .sync_i(sync_i),
        .check_fail_i(check_fail_i), .eeprom_done_i(eeprom_done_i),
        .filter_start_i(filter_start_i), .cfg_we_i(cfg_we_i), .cfg_re_i(cfg_re_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_ready_o(cfg_ready_o),
        .rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .boot_eeprom_o(boot_eeprom_o),
        .eeprom_fetch_o(eeprom_fetch_o), .filter_run_o(filter_run_o),
        .filter_restart_o(filter_restart_o), .word_strobe_o(word_strobe_o),
        .modulator_clk_o(modulator_clk_o), .modulator_align_pulse_o(modulator_align_pulse_o));

    cfg_source_model partner (
        .clk_i(clk_i), .nrst_i(nrst_i), .ready_i(cfg_ready_o), .eeprom_mode_i(boot_eeprom_o),
        .delay_i(delay), .done_o(eeprom_done_i), .start_o(filter_start_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    function logic [31:0] draw();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one nibble per test, lowest nibble first
    function logic [23:0] result_of(input logic [4:0] f);
        result_of = 24'h000000;
        for (int k = 0; k < 5; k++)
            result_of[4*k +: 4] = f[k] ? CHECK_FAIL : CHECK_PASS;
    endfunction

    task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task end_of_test();
        $display("mismatches %0d of %0d comparisons", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clk_i);
        cfg_addr_i  = a;
        cfg_wdata_i = d;
        cfg_we_i    = 1'b1;
        @(negedge clk_i);
        cfg_we_i = 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
        d  = 24'hFFFFFF;
        ok = 1'b0;
        @(negedge clk_i);
        cfg_addr_i = a;
        cfg_re_i   = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            @(negedge clk_i);
            cfg_re_i = 1'b0;
            if (rd_valid_o === 1'b1 && !ok)
            begin
                ok = 1'b1;
                d  = rdata_o;
            end
        end
    endtask

    task sync_test();
        int n, first, hi, mc;
        wr(OFS_FILTER_SETUP, 24'h000000);
        sync_i = 1'b1;
        n = 0;
        repeat (20)
        begin
            @(negedge clk_i);
            if (filter_restart_o === 1'b1)
                n++;
        end
        check("gated restart count", n, 0);
        sync_i = 1'b0;
        repeat (8) @(negedge clk_i);
        wr(OFS_FILTER_SETUP, 24'h000001);
        sync_i = 1'b1;
        n = 0;
        while (filter_restart_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        check("restart pulse", filter_restart_o, 1'b1);
        check("align pin", modulator_align_pulse_o, 1'b1);
        first = 0;
        hi = 1;
        mc = 0;
        for (n = 1; n <= WP + 2; n++)
        begin
            @(negedge clk_i);
            if (n < 10 && modulator_align_pulse_o === 1'b1)
                hi++;
            // the modulator clock high half follows the align launch directly
            if (n <= MD / 2 && modulator_clk_o === 1'b1)
                mc++;
            if (word_strobe_o === 1'b1 && first == 0)
                first = n;
        end
        sync_i = 1'b0;
        check("align pin length", hi, MD);
        check("modulator clock after align", mc, MD / 2);
        check("first word after restart", first, WP);
    endtask

    initial
    begin
        logic [23:0] d;
        logic [31:0] v;
        logic        ok, b;
        int          n;
        nrst_i = 1'b0;
        boot_mode_i = 1'b0;
        sync_i = 1'b0;
        check_fail_i = 5'h00;
        cfg_we_i = 1'b0;
        cfg_re_i = 1'b0;
        cfg_addr_i = 8'h00;
        cfg_wdata_i = 24'h000000;
        delay = 8'h00;
        for (int run = 0; run < 3; run++)
        begin
            v = draw();
            b = (run == 0) ? 1'b1 : (run == 1) ? 1'b0 : v[0];
            @(negedge clk_i);
            nrst_i = 1'b0;
            boot_mode_i = b;
            check_fail_i = (run == 0) ? 5'h00 : v[5:1];
            delay = v[15:8];
            repeat (12) @(negedge clk_i);
            check("ready in reset", cfg_ready_o, 1'b0);
            check("run in reset", filter_run_o, 1'b0);
            nrst_i = 1'b1;
            wr(OFS_USER_INFO_A, v[31:8]);
            rd(OFS_USER_INFO_A, d, ok);
            check("read during test", ok, 1'b0);
            n = 6;
            while (cfg_ready_o !== 1'b1 && n < ST + 20)
            begin
                @(negedge clk_i);
                n++;
            end
            check("self test length ok", n >= ST && n <= ST + 10, 1'b1);
            check("boot mode", boot_eeprom_o, b);
            check("fetching", eeprom_fetch_o, b);
            check("idle before start", filter_run_o, 1'b0);
            rd(OFS_CHECK_RESULT, d, ok);
            check("check result", d, result_of(check_fail_i));
            rd(OFS_USER_INFO_A, d, ok);
            check("write during test", d, USER_INFO_RST);
            n = 0;
            while (filter_run_o !== 1'b1 && n < 300)
            begin
                @(negedge clk_i);
                n++;
            end
            check("running", filter_run_o, 1'b1);
            check("fetch over", eeprom_fetch_o, 1'b0);
            for (int k = 0; k < 4; k++)
            begin
                v = draw();
                wr(k[0] ? OFS_USER_INFO_B : OFS_USER_INFO_A, v[23:0]);
                rd(k[0] ? OFS_USER_INFO_B : OFS_USER_INFO_A, d, ok);
                check("user info", d, v[23:0]);
            end
            wr(OFS_CHECK_RESULT, 24'h123456);
            rd(OFS_CHECK_RESULT, d, ok);
            check("result read only", d, result_of(check_fail_i));
            rd(8'h2E, d, ok);
            check("unmapped read", d, 24'h000000);
            sync_test();
        end
        end_of_test();
    end
endmodule // reset_boot_sync_control_tb

`default_nettype wire
